// ### tws_ctrl.sv
// two-wire serial controller: master/slave byte engine with receive fifo
`timescale 1ns/1ns

// byte fifo of flip-flops with valid and ready on both sides
module tws_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // flags follow the occupancy count
    assign in_ready_o = cnt_q != (AW + 1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    // pointers and count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule : tws_fifo

// Overview of operation
// - lost arbitration drops to slave automatically
// - standard and fast bus rates supported
// - seven or extended ten bit addressing; only seven bit addresses are sent and matched
// - start byte sequence not generated
// - repeated start without stop between
// - generate and check acknowledge every byte
// - correct operation with several masters
// - slave answers the general call
// - quick command: address only, no data
// - none or one to three internal address bytes
// - master or slave, single or sequential
// - separate transmit and receive dma requests
// - one combined interrupt output
// - lines only pulled low or released
// - bit clock from programmable core divider
// - bus idle only when both lines high
// - start and stop frame every transfer
// - eight bits, msb first, then acknowledge
// - master samples ack, flags missing one
// - master holds clock low awaiting data
module tws_ctrl
    import tws_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire tws_cfg_type cfg_i,
    input wire tws_cmd_type cmd_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    input wire logic rx_ready_i,
    output tws_stat_type stat_o,
    output logic irq_o
);
    tws_mst_type m_st_q;
    tws_kind_type kind_q;
    tws_slv_type s_st_q;
    logic [15:0] cnt_q;
    logic [15:0] qtr;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [1:0] iidx_q;
    logic rdph_q;
    logic stop_pend_q;
    logic ack_q;
    logic m_scl_low_q;
    logic m_sda_low_q;
    logic nack_p_q;
    logic arb_p_q;
    logic done_p_q;
    logic [3:0] s_bit_q;
    logic [7:0] s_sh_q;
    logic s_sda_low_q;
    logic s_scl_low_q;
    logic s_rw_q;
    logic s_gc_q;
    logic s_need_q;
    logic scl_prev_q;
    logic sda_prev_q;
    logic bus_busy_q;
    logic push_q;
    logic [7:0] push_data_q;
    logic fifo_in_ready;
    logic stall;
    logic tick;
    logic bus_idle;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic s_match;
    logic s_push;
    logic m_push;
    logic tx_take;
    logic m_to_iadr;
    logic m_restart;
    logic m_to_rx;
    logic m_to_tx;

    // bus condition decode from the sampled lines
    assign scl_rise = scl_i && !scl_prev_q;
    assign scl_fall = !scl_i && scl_prev_q;
    assign start_det = scl_i && scl_prev_q && sda_prev_q && !sda_i;
    assign stop_det = scl_i && scl_prev_q && !sda_prev_q && sda_i;
    assign bus_idle = !bus_busy_q && scl_i && sda_i;
    assign tx_take = tx_valid_i && tx_ready_o;

    // divider: programmed quarter period, else the selected standard one
    assign qtr = (cfg_i.qtr_div != 16'h0000) ? cfg_i.qtr_div :
                 (cfg_i.fast ? TWS_FAST_QTR : TWS_STD_QTR);
    assign stall = (ph_q == TWS_PH_HIGH) && !scl_i;
    assign tick = (cnt_q == 16'h0000) && !stall &&
                  (m_st_q == TWS_M_START || m_st_q == TWS_M_BIT || m_st_q == TWS_M_STOP);

    // next step of the master after a byte, decided while the clock is held
    always_comb begin
        m_to_iadr = (m_st_q == TWS_M_WAIT) && ack_q && (iidx_q != 2'h0) &&
                    ((kind_q == TWS_K_ADDR && !rdph_q && !cfg_i.quick) ||
                     kind_q == TWS_K_IADR);
        m_restart = (m_st_q == TWS_M_WAIT) && ack_q && (iidx_q == 2'h0) &&
                    (kind_q == TWS_K_IADR) && cfg_i.rd;
        m_to_rx = (m_st_q == TWS_M_WAIT) && ack_q &&
                  ((kind_q == TWS_K_ADDR && rdph_q && !cfg_i.quick) ||
                   kind_q == TWS_K_RXD);
        m_to_tx = (m_st_q == TWS_M_WAIT) && ack_q && !cfg_i.quick &&
                  (kind_q == TWS_K_TXD ||
                   (kind_q == TWS_K_ADDR && !rdph_q && iidx_q == 2'h0) ||
                   (kind_q == TWS_K_IADR && iidx_q == 2'h0 && !cfg_i.rd));
    end

    // slave address match, own address or general call write
    assign s_match = (m_st_q == TWS_M_IDLE) &&
                     (s_sh_q[7:1] == cfg_i.own_addr ||
                      (s_sh_q[7:1] == TWS_GCALL_ADDR && !s_sh_q[0]));
    assign m_push = (m_st_q == TWS_M_BIT) && tick && (ph_q == 2'h3) &&
                    (bit_q == TWS_ACK_BIT) && (kind_q == TWS_K_RXD);
    assign s_push = (s_st_q == TWS_S_RX) && scl_fall && (s_bit_q == TWS_LAST_BIT);

    // line history and busy tracking between start and stop
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            bus_busy_q <= 1'b0;
        end else begin
            scl_prev_q <= scl_i;
            sda_prev_q <= sda_i;
            if (start_det) begin
                bus_busy_q <= 1'b1;
            end else if (stop_det) begin
                bus_busy_q <= 1'b0;
            end
        end
    end

    // quarter period counter, frozen while another device stretches the clock
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 16'h0000;
        end else if (m_st_q == TWS_M_IDLE || m_st_q == TWS_M_WAIT || tick) begin
            cnt_q <= qtr - 16'h0001;
        end else if (!stall) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    // master sequencer: start, bits with acknowledge, hold, stop
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            m_st_q <= TWS_M_IDLE;
            kind_q <= TWS_K_ADDR;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            iidx_q <= 2'h0;
            rdph_q <= 1'b0;
            stop_pend_q <= 1'b0;
            ack_q <= 1'b0;
            m_scl_low_q <= 1'b0;
            m_sda_low_q <= 1'b0;
            nack_p_q <= 1'b0;
            arb_p_q <= 1'b0;
            done_p_q <= 1'b0;
        end else begin
            nack_p_q <= 1'b0;
            arb_p_q <= 1'b0;
            done_p_q <= 1'b0;
            if (cmd_i.stop) begin
                stop_pend_q <= 1'b1;
            end
            case (m_st_q)
                TWS_M_IDLE: begin
                    m_scl_low_q <= 1'b0;
                    m_sda_low_q <= 1'b0;
                    ph_q <= 2'h0;
                    stop_pend_q <= cmd_i.stop;
                    if (cmd_i.start && cfg_i.master_en && bus_idle) begin
                        m_st_q <= TWS_M_START;
                        rdph_q <= cfg_i.rd && (cfg_i.iadr_size == 2'h0);
                        iidx_q <= cfg_i.iadr_size;
                    end
                end
                TWS_M_START: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        TWS_PH_RISE: m_scl_low_q <= 1'b0;
                        TWS_PH_HIGH: m_sda_low_q <= 1'b1;
                        TWS_PH_SET: m_sda_low_q <= 1'b0;
                        default: begin
                            m_scl_low_q <= 1'b1;
                            m_st_q <= TWS_M_BIT;
                            kind_q <= TWS_K_ADDR;
                            bit_q <= 4'h0;
                            sh_q <= {cfg_i.dev_addr, rdph_q};
                        end
                    endcase
                end
                TWS_M_BIT: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        TWS_PH_SET: begin
                            if (bit_q != TWS_ACK_BIT) begin
                                m_sda_low_q <= (kind_q != TWS_K_RXD) && !sh_q[7];
                            end else if (kind_q == TWS_K_RXD) begin
                                ack_q <= !stop_pend_q;
                                m_sda_low_q <= !stop_pend_q;
                            end else begin
                                m_sda_low_q <= 1'b0;
                            end
                        end
                        TWS_PH_RISE: m_scl_low_q <= 1'b0;
                        TWS_PH_HIGH: begin
                            if (bit_q != TWS_ACK_BIT) begin
                                sh_q <= {sh_q[6:0], sda_i};
                            end else if (kind_q != TWS_K_RXD) begin
                                ack_q <= !sda_i;
                                nack_p_q <= sda_i;
                            end
                            if (!m_sda_low_q && !sda_i &&
                                ((bit_q != TWS_ACK_BIT) != (kind_q == TWS_K_RXD))) begin
                                m_st_q <= TWS_M_IDLE;
                                m_scl_low_q <= 1'b0;
                                arb_p_q <= 1'b1;
                            end
                        end
                        default: begin
                            m_scl_low_q <= 1'b1;
                            if (bit_q == TWS_ACK_BIT) begin
                                m_st_q <= TWS_M_WAIT;
                            end else begin
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    endcase
                end
                TWS_M_WAIT: begin
                    ph_q <= 2'h0;
                    bit_q <= 4'h0;
                    if (m_to_iadr) begin
                        kind_q <= TWS_K_IADR;
                        sh_q <= tws_iadr_byte(cfg_i.iadr, iidx_q - 2'h1);
                        iidx_q <= iidx_q - 2'h1;
                        m_st_q <= TWS_M_BIT;
                    end else if (m_restart) begin
                        rdph_q <= 1'b1;
                        m_sda_low_q <= 1'b0;
                        m_st_q <= TWS_M_START;
                    end else if (m_to_rx) begin
                        if (!push_q) begin
                            kind_q <= TWS_K_RXD;
                            m_st_q <= TWS_M_BIT;
                        end
                    end else if (m_to_tx) begin
                        if (tx_take) begin
                            kind_q <= TWS_K_TXD;
                            sh_q <= tx_data_i;
                            m_st_q <= TWS_M_BIT;
                        end else if (stop_pend_q) begin
                            m_st_q <= TWS_M_STOP;
                        end
                    end else if (!(kind_q == TWS_K_RXD && push_q)) begin
                        m_st_q <= TWS_M_STOP;
                    end
                end
                TWS_M_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        TWS_PH_SET: m_sda_low_q <= 1'b1;
                        TWS_PH_RISE: m_scl_low_q <= 1'b0;
                        TWS_PH_HIGH: m_sda_low_q <= 1'b0;
                        default: begin
                            m_st_q <= TWS_M_IDLE;
                            done_p_q <= 1'b1;
                        end
                    endcase
                end
                default: m_st_q <= TWS_M_IDLE;
            endcase
        end
    end

    // slave engine follows every frame; it answers only with the master idle
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_st_q <= TWS_S_IDLE;
            s_bit_q <= 4'h0;
            s_sh_q <= 8'h00;
            s_sda_low_q <= 1'b0;
            s_rw_q <= 1'b0;
            s_gc_q <= 1'b0;
            s_need_q <= 1'b0;
        end else if (start_det && cfg_i.slave_en) begin
            s_st_q <= TWS_S_ADDR;
            s_bit_q <= 4'h0;
            s_sda_low_q <= 1'b0;
            s_need_q <= 1'b0;
            s_gc_q <= 1'b0;
        end else if (stop_det || !cfg_i.slave_en) begin
            s_st_q <= TWS_S_IDLE;
            s_sda_low_q <= 1'b0;
            s_need_q <= 1'b0;
        end else begin
            case (s_st_q)
                TWS_S_ADDR, TWS_S_RX: begin
                    if (scl_rise && s_bit_q != TWS_ACK_BIT) begin
                        s_sh_q <= {s_sh_q[6:0], sda_i};
                    end
                    if (scl_fall) begin
                        if (s_bit_q == TWS_ACK_BIT) begin
                            s_sda_low_q <= 1'b0;
                            s_bit_q <= 4'h0;
                            if (s_st_q == TWS_S_ADDR) begin
                                s_st_q <= s_rw_q ? TWS_S_TX : TWS_S_RX;
                                s_need_q <= s_rw_q;
                            end
                        end else if (s_bit_q == TWS_LAST_BIT) begin
                            s_bit_q <= TWS_ACK_BIT;
                            if (s_st_q == TWS_S_RX) begin
                                s_sda_low_q <= 1'b1;
                            end else if (s_match) begin
                                s_sda_low_q <= 1'b1;
                                s_rw_q <= s_sh_q[0];
                                s_gc_q <= s_sh_q[7:1] == TWS_GCALL_ADDR;
                            end else begin
                                s_st_q <= TWS_S_IDLE;
                            end
                        end else begin
                            s_bit_q <= s_bit_q + 4'h1;
                        end
                    end
                end
                TWS_S_TX: begin
                    if (s_need_q) begin
                        if (tx_take) begin
                            s_sh_q <= tx_data_i;
                            s_sda_low_q <= !tx_data_i[7];
                            s_need_q <= 1'b0;
                        end
                    end else if (scl_rise && s_bit_q == TWS_ACK_BIT && sda_i) begin
                        s_st_q <= TWS_S_IDLE;
                    end else if (scl_fall) begin
                        if (s_bit_q == TWS_ACK_BIT) begin
                            s_bit_q <= 4'h0;
                            s_need_q <= 1'b1;
                        end else if (s_bit_q == TWS_LAST_BIT) begin
                            s_bit_q <= TWS_ACK_BIT;
                            s_sda_low_q <= 1'b0;
                        end else begin
                            s_bit_q <= s_bit_q + 4'h1;
                            s_sh_q <= {s_sh_q[6:0], 1'b0};
                            s_sda_low_q <= !s_sh_q[6];
                        end
                    end
                end
                default: s_st_q <= TWS_S_IDLE;
            endcase
        end
    end

    // slave stretches the clock while the fifo or the transmit data lags
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            s_scl_low_q <= 1'b0;
        end else begin
            s_scl_low_q <= ((s_st_q == TWS_S_RX && s_bit_q == TWS_ACK_BIT && push_q) ||
                            (s_st_q == TWS_S_TX && s_need_q)) &&
                           (!scl_i || s_scl_low_q);
        end
    end

    // received byte waits here until the fifo accepts it
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            push_q <= 1'b0;
            push_data_q <= 8'h00;
        end else if (m_push || s_push) begin
            push_q <= 1'b1;
            push_data_q <= m_push ? sh_q : s_sh_q;
        end else if (fifo_in_ready) begin
            push_q <= 1'b0;
        end
    end

    tws_fifo #(
        .WIDTH(TWS_BYTE_W),
        .DEPTH(TWS_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i(ref_clk_i),
        .rst_i(sys_rst_i),
        .in_valid_i(push_q),
        .in_data_i(push_data_q),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(rx_valid_o),
        .out_data_o(rx_data_o),
        .out_ready_i(rx_ready_i)
    );

    // transmit request toward the dma channel
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            tx_ready_o <= 1'b0;
        end else begin
            tx_ready_o <= ((m_to_tx && !stop_pend_q) || s_need_q) && !tx_take;
        end
    end

    // open-drain pins: level always low, enable pulls the wired-and line
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= m_scl_low_q || s_scl_low_q;
            sda_oe_o <= m_sda_low_q || s_sda_low_q;
        end
    end

    // status: nack, arb_lost and done sticky, a new event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            stat_o <= '0;
            irq_o <= 1'b0;
        end else begin
            stat_o.nack <= nack_p_q || (stat_o.nack && !cmd_i.clr);
            stat_o.arb_lost <= arb_p_q || (stat_o.arb_lost && !cmd_i.clr);
            stat_o.done <= done_p_q || (stat_o.done && !cmd_i.clr);
            stat_o.busy <= m_st_q != TWS_M_IDLE;
            stat_o.bus_idle <= bus_idle;
            stat_o.slave_sel <= s_st_q == TWS_S_RX || s_st_q == TWS_S_TX;
            stat_o.gen_call <= s_gc_q;
            irq_o <= stat_o.nack || stat_o.arb_lost || stat_o.done;
        end
    end
endmodule : tws_ctrl

// ### tws_ctrl_chk.sv
// checker: port properties of the two-wire serial controller
`timescale 1ns/1ns
module tws_ctrl_chk
    import tws_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire tws_cfg_type cfg_i,
    input wire tws_cmd_type cmd_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic tx_valid_i,
    input wire logic tx_ready_o,
    input wire tws_stat_type stat_o,
    input wire logic irq_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_lines_only_low: assert property (!scl_o && !sda_o)
        else $error("line driven high");
    a_irq_combined: assert property (irq_o == $past(|stat_o[6:4]))
        else $error("irq not or of flags");
    a_tx_taken: assert property (tx_valid_i && tx_ready_o |=> !tx_ready_o)
        else $error("tx ready stays after take");
    a_nack_sticky: assert property (stat_o.nack && !cmd_i.clr |=> stat_o.nack)
        else $error("nack lost");
    a_arb_sticky: assert property (stat_o.arb_lost && !cmd_i.clr |=> stat_o.arb_lost)
        else $error("arb flag lost");
    a_done_released: assert property ($rose(stat_o.done) |-> !sda_oe_o && !scl_oe_o)
        else $error("lines held after done");
    a_start_issued: assert property (cmd_i.start && cfg_i.master_en && stat_o.bus_idle
        && !stat_o.busy |-> ##[1:1000] (sda_oe_o && !scl_oe_o)) else $error("no start");
    a_busy_not_idle: assert property ($rose(sda_oe_o) |-> ##[1:4] !stat_o.bus_idle)
        else $error("idle while data low");
    c_done: cover property ($rose(stat_o.done));
    c_nack: cover property ($rose(stat_o.nack));
    c_tx: cover property (tx_valid_i && tx_ready_o);
endmodule : tws_ctrl_chk
bind tws_ctrl tws_ctrl_chk u_chk (.ref_clk_i, .sys_rst_i, .cfg_i, .cmd_i, .scl_o, .scl_oe_o,
    .sda_o, .sda_oe_o, .tx_valid_i, .tx_ready_o, .stat_o, .irq_o);

// ### tws_ctrl_tb_top.sv
// testbench: master transfers against a slave model on a pulled-up bus
`timescale 1ns/1ns
module tws_ctrl_tb_top
    import tws_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h2A;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    tws_cfg_type cfg;
    tws_cmd_type cmd = '0;
    tws_stat_type stat;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_ready = 1'b0;
    logic tx_ready, rx_valid, scl_oe, sda_oe, pull, irq;
    logic [7:0] rx_data;
    int error_cnt = 0;
    int check_count = 0;
    wire scl = !scl_oe;
    wire sda = !(sda_oe || pull);
    tws_ctrl uut (.ref_clk_i, .sys_rst_i, .cfg_i(cfg), .cmd_i(cmd), .scl_i(scl), .scl_o(),
        .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .rx_ready_i(rx_ready), .stat_o(stat), .irq_o(irq));
    tws_slave_model #(.ADDR(ADDR)) m (.scl_i(scl), .sda_i(sda), .pull_o(pull));
    always #5 ref_clk_i = ~ref_clk_i;
    // compare, count and report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input tws_cmd_type c);
        cmd <= c;
        @(posedge ref_clk_i);
        cmd <= 3'h0;
    endtask : tick
    // clear status, wait for idle bus, start
    task automatic go(input logic r, input logic q, input logic [6:0] da, input logic st);
        int i;
        cfg.rd <= r;
        cfg.quick <= q;
        cfg.dev_addr <= da;
        tick(3'h1);
        do @(posedge ref_clk_i); while (stat.bus_idle !== 1'b1 && ++i < 200);
        if (stat.bus_idle !== 1'b1) error_cnt++;
        tick({1'b1, st, 1'b0});
    endtask : go
    task automatic wait_done();
        for (int i = 0; i < 5000 && stat.done !== 1'b1; i++) @(posedge ref_clk_i);
        if (stat.done !== 1'b1) error_cnt++;
    endtask : wait_done
    task automatic feed(input logic [7:0] b);
        int i = 0;
        do @(posedge ref_clk_i); while (tx_ready !== 1'b1 && ++i < 5000);
        if (tx_ready !== 1'b1) error_cnt++;
        repeat (20) @(posedge ref_clk_i);
        chk({7'h00, scl}, 8'h00);
        tx_valid <= 1'b1;
        tx_data <= b;
        @(posedge ref_clk_i);
        tx_valid <= 1'b0;
    endtask : feed
    task automatic t_write();
        int nb0 = m.nb;
        go(1'b0, 1'b0, ADDR, 1'b0);
        feed(8'hC3);
        feed(8'h5A);
        tick(3'h2);
        wait_done();
        chk(m.wb, 8'h5A);
        chk(8'(m.nb - nb0), 8'h03);
        chk({7'h00, stat.nack}, 8'h00);
        $display("test write done");
    endtask : t_write
    task automatic t_read();
        cfg.iadr_size <= 2'h0;
        go(1'b1, 1'b0, ADDR, 1'b1);
        wait_done();
        chk(rx_data, 8'hA5);
        chk({7'h00, rx_valid}, 8'h01);
        rx_ready <= 1'b1;
        @(posedge ref_clk_i);
        rx_ready <= 1'b0;
        $display("test read done");
    endtask : t_read
    task automatic t_quick_nack();
        int nb0 = m.nb;
        go(1'b0, 1'b1, ADDR, 1'b1);
        wait_done();
        chk({7'h00, stat.nack}, 8'h00);
        chk(8'(m.nb - nb0), 8'h00);
        go(1'b0, 1'b0, ADDR ^ 7'h01, 1'b0);
        wait_done();
        chk({6'h00, stat.nack, irq}, 8'h03);
        $display("test quick and nack done");
    endtask : t_quick_nack
    task automatic end_sim();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // reset, then the scenarios in turn
    initial begin
        cfg = '{master_en: 1'b1, slave_en: 1'b0, rd: 1'b0, quick: 1'b0, fast: 1'b1,
            iadr_size: 2'h1, dev_addr: ADDR, iadr: 24'h00003C, own_addr: 7'h55, qtr_div: 16'h0004};
        repeat (10) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        t_write();
        t_read();
        t_quick_nack();
        end_sim();
    end
    // watchdog
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end
endmodule : tws_ctrl_tb_top

// ### tws_pkg.sv
// package: constants, carriers and states of the two-wire serial controller
package tws_pkg;
    localparam int unsigned TWS_CLK_HZ = 100_000_000;
    localparam int unsigned TWS_STD_HZ = 100_000;
    localparam int unsigned TWS_FAST_HZ = 400_000;
    // quarter bit period in clocks, rounded up so the rate stays under its ceiling
    localparam logic [15:0] TWS_STD_QTR =
        16'((TWS_CLK_HZ + 4 * TWS_STD_HZ - 1) / (4 * TWS_STD_HZ));
    localparam logic [15:0] TWS_FAST_QTR =
        16'((TWS_CLK_HZ + 4 * TWS_FAST_HZ - 1) / (4 * TWS_FAST_HZ));
    localparam int TWS_BYTE_W = 8;
    localparam int TWS_FIFO_DEPTH = 32;
    localparam logic [3:0] TWS_LAST_BIT = 4'h7;
    localparam logic [3:0] TWS_ACK_BIT = 4'h8;
    localparam logic [6:0] TWS_GCALL_ADDR = 7'h00;
    localparam logic [1:0] TWS_PH_SET = 2'h0;
    localparam logic [1:0] TWS_PH_RISE = 2'h1;
    localparam logic [1:0] TWS_PH_HIGH = 2'h2;

    typedef struct packed {
        logic master_en;
        logic slave_en;
        logic rd;
        logic quick;
        logic fast;
        logic [1:0] iadr_size;
        logic [6:0] dev_addr;
        logic [23:0] iadr;
        logic [6:0] own_addr;
        logic [15:0] qtr_div;
    } tws_cfg_type;

    typedef struct packed {
        logic start;
        logic stop;
        logic clr;
    } tws_cmd_type;

    typedef struct packed {
        logic nack;
        logic arb_lost;
        logic done;
        logic busy;
        logic bus_idle;
        logic slave_sel;
        logic gen_call;
    } tws_stat_type;

    typedef enum logic [2:0] {TWS_M_IDLE, TWS_M_START, TWS_M_BIT, TWS_M_WAIT, TWS_M_STOP}
        tws_mst_type;
    typedef enum logic [1:0] {TWS_K_ADDR, TWS_K_IADR, TWS_K_TXD, TWS_K_RXD} tws_kind_type;
    typedef enum logic [1:0] {TWS_S_IDLE, TWS_S_ADDR, TWS_S_RX, TWS_S_TX} tws_slv_type;

    // picks one internal address byte, index 2 is the most significant
    function automatic logic [7:0] tws_iadr_byte(input logic [23:0] iadr,
                                                 input logic [1:0] idx);
        case (idx)
            2'h2: tws_iadr_byte = iadr[23:16];
            2'h1: tws_iadr_byte = iadr[15:8];
            default: tws_iadr_byte = iadr[7:0];
        endcase
    endfunction : tws_iadr_byte
endpackage : tws_pkg

// ### tws_slave_model.sv
// slave model: acks its address and writes, returns counted read bytes
`timescale 1ns/1ns
module tws_slave_model #(parameter logic [6:0] ADDR = 7'h2A) (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic pull_o
);
    logic [7:0] sh = 8'h00, wb = 8'h00;
    logic [7:0] rdb = 8'hA5;
    logic hdr = 1'b0;
    logic act = 1'b0;
    logic rd = 1'b0;
    int n = -1;
    int nb = 0;
    initial pull_o = 1'b0;
    // start opens a frame, stop closes it
    always @(sda_i) if (scl_i === 1'b1) begin
        n = sda_i ? -1 : 0;
        hdr = !sda_i;
        act = 1'b0;
        pull_o = 1'b0;
    end
    // msb first, ninth clock is the acknowledge
    always @(posedge scl_i) if (n >= 0) begin
        if (n < 8) sh = {sh[6:0], sda_i};
        if (n == 8 && !hdr && rd) rdb = rdb + 8'h11;
        if (n == 8 && !hdr && act && !rd) nb = nb + 1;
        if (n == 8 && !hdr && act && !rd) wb = sh;
        if (n == 8 && rd && !hdr && sda_i) n = -1;
        else n = (n == 8) ? 0 : n + 1;
        if (n == 0) hdr = 1'b0;
    end
    // data changes only while the clock is low
    always @(negedge scl_i) if (n >= 0) begin
        if (n == 8 && hdr) begin
            act = (sh[7:1] == ADDR);
            rd = sh[0];
        end
        if (n == 8) pull_o = act && (hdr || !rd);
        else pull_o = act && rd && !hdr && !rdb[7 - n];
    end
endmodule : tws_slave_model
